// File: rtl/bib_pkg.sv
/*
  Constants for the bus information block register group: local offsets,
  reset values, field positions and configuration-space load offsets.
  Assumes a 32-bit byte-addressed local register port.
*/
package bib_pkg;
  // Local register offsets (byte addresses)
  localparam logic [7:0] OFS_HEADER    = 8'h18;
  localparam logic [7:0] OFS_BUS_NAME  = 8'h1c;
  localparam logic [7:0] OFS_OPTIONS   = 8'h20;
  localparam logic [7:0] OFS_UID_UPPER = 8'h24;
  localparam logic [7:0] OFS_UID_LOWER = 8'h28;
  // Configuration-space identifier load offsets
  localparam logic [7:0] CFG_UID_UPPER     = 8'h70;
  localparam logic [7:0] CFG_UID_UPPER_ALT = 8'h80;
  localparam logic [7:0] CFG_UID_LOWER     = 8'h74;
  localparam logic [7:0] CFG_UID_LOWER_ALT = 8'h84;
  // Remote quadlet indices within the image (0x400 >> 2 based)
  localparam logic [2:0] QD_HEADER    = 3'h0;
  localparam logic [2:0] QD_BUS_NAME  = 3'h1;
  localparam logic [2:0] QD_OPTIONS   = 3'h2;
  localparam logic [2:0] QD_UID_UPPER = 3'h3;
  localparam logic [2:0] QD_UID_LOWER = 3'h4;
  // Reset and constant values
  localparam logic [31:0] RST_HEADER   = 32'h0000_0000;
  localparam logic [31:0] BUS_NAME_VAL = 32'h3133_3934;
  localparam logic [31:0] RST_OPTIONS  = 32'h0000_a002;
  localparam logic [31:0] RST_UID      = 32'h0000_0000;
  // Bus options fields
  localparam int         BLK_LSB     = 12;
  localparam int         BLK_MSB     = 15;
  localparam logic [3:0] BLK_RST     = 4'ha;
  localparam logic [3:0] BLK_MIN     = 4'h8;
  localparam logic [2:0] SPEED_CODE  = 3'h2;
  localparam logic [7:0] OPT_LO_RST  = 8'h00;
  localparam logic [4:0] OPT_HI_RST  = 5'h00;
  localparam int         OPT_LO_LSB  = 16;
  localparam int         OPT_HI_LSB  = 27;
endpackage

// File: rtl/bib_regs.sv
/*
  Bus information block register group: image header, bus name word, bus
  options, and the 64-bit unique identifier with its one-shot load and lock.
  Assumes a simple local register port, a configuration-write strobe from the
  host bus interface, an EEPROM loader port, and a remote quadlet read port.
*/
`timescale 1ns/100ps
// Notes on behaviour
// - Header word at 18h, zero after reset, remote quadlet zero of the image.
// - Bus name word at 1Ch is read-only, always 32'h31333934.
// - Bus name word served remotely as first bus-info quadlet, locally at 1Ch.
// - Bus options at 20h, reset 0000A002h, second bus-info quadlet remotely.
// - Largest-block code gives 2^(code+1) bytes, never under 512.
// - Block writes longer than that byte count may get a type-error acknowledge.
// - Hard reset loads code for 2048 bytes; soft reset leaves it.
// - Speed field bits 2:0 read-only, returns 010.
// - Bus options bits 11:3 read as zero.
// - Bits 23:16 and 31:27 of bus options are plain writable storage.
// - Upper identifier at 24h clears on hard reset, third bus-info quadlet.
// - With an EEPROM detected, identifier loads from it after host reset.
// - Without EEPROM, upper identifier takes one config write to 70h or 80h.
// - After either load completes, identifier words lock read-only.
// - Lower identifier at 28h behaves alike, loaded via config 74h or 84h.
module bib_regs
(
  // Clock, resets, enable
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        soft_rst_i,
  input  wire logic        clk_en_i,
  // Local register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic      [31:0] reg_rdata_o,
  // Configuration-space write
  input  wire logic        cfg_wr_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [31:0] cfg_wdata_i,
  // EEPROM loader
  input  wire logic        eeprom_present_i,
  input  wire logic        eeprom_valid_i,
  input  wire logic [63:0] eeprom_uid_i,
  // Remote quadlet read and block-length check
  input  wire logic        rem_rd_i,
  input  wire logic [2:0]  rem_quad_i,
  output logic      [31:0] rem_rdata_o,
  input  wire logic        blk_wr_i,
  input  wire logic [15:0] blk_len_i,
  output logic             blk_type_err_o,
  // Status
  output logic             uid_locked_o,
  output logic      [3:0]  blk_code_o
);

  logic [31:0] header_q;
  logic [3:0]  blk_code_q;
  logic [7:0]  opt_lo_q;
  logic [4:0]  opt_hi_q;
  logic [31:0] uid_hi_q;
  logic [31:0] uid_lo_q;
  logic        hi_done_q;
  logic        lo_done_q;
  logic        locked_q;

  // Quadlet index to word, shared by the local and remote read paths
  function automatic logic [31:0] word_of
  (
    input logic [2:0]  q,
    input logic [31:0] hdr,
    input logic [31:0] opt,
    input logic [31:0] hi,
    input logic [31:0] lo
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (q)
      bib_pkg::QD_HEADER:    w = hdr;
      bib_pkg::QD_BUS_NAME:  w = bib_pkg::BUS_NAME_VAL;
      bib_pkg::QD_OPTIONS:   w = opt;
      bib_pkg::QD_UID_UPPER: w = hi;
      bib_pkg::QD_UID_LOWER: w = lo;
      default:               w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // Assembled options word: fixed speed, zero middle, stored upper bits
  wire logic [31:0] options_w = {opt_hi_q, 3'b000, opt_lo_q, blk_code_q, 9'h000, bib_pkg::SPEED_CODE};

  // Local decode to a quadlet index
  wire logic        hit_hdr  = reg_addr_i == bib_pkg::OFS_HEADER;
  wire logic        hit_opt  = reg_addr_i == bib_pkg::OFS_OPTIONS;
  wire logic [2:0]  loc_quad = (reg_addr_i == bib_pkg::OFS_HEADER)    ? bib_pkg::QD_HEADER :
                               (reg_addr_i == bib_pkg::OFS_BUS_NAME)  ? bib_pkg::QD_BUS_NAME :
                               (reg_addr_i == bib_pkg::OFS_OPTIONS)   ? bib_pkg::QD_OPTIONS :
                               (reg_addr_i == bib_pkg::OFS_UID_UPPER) ? bib_pkg::QD_UID_UPPER :
                               (reg_addr_i == bib_pkg::OFS_UID_LOWER) ? bib_pkg::QD_UID_LOWER : 3'h7;

  // Identifier load paths
  wire logic        ee_load  = eeprom_present_i && eeprom_valid_i && !locked_q;
  wire logic        cfg_ok   = cfg_wr_i && !eeprom_present_i && !locked_q;
  wire logic        cfg_hi   = cfg_ok && !hi_done_q &&
                               (cfg_addr_i == bib_pkg::CFG_UID_UPPER || cfg_addr_i == bib_pkg::CFG_UID_UPPER_ALT);
  wire logic        cfg_lo   = cfg_ok && !lo_done_q &&
                               (cfg_addr_i == bib_pkg::CFG_UID_LOWER || cfg_addr_i == bib_pkg::CFG_UID_LOWER_ALT);

  // Largest-block byte count 2^(code+1); codes below the minimum clamp up
  wire logic [3:0]  code_eff = (blk_code_q < bib_pkg::BLK_MIN) ? bib_pkg::BLK_MIN : blk_code_q;
  wire logic [16:0] max_rec  = 17'(17'h0_0001 << (5'(code_eff) + 5'h01));
  wire logic        too_long = blk_wr_i && ({1'b0, blk_len_i} > max_rec);

  // Next values of the stored registers
  wire logic        opt_wr      = reg_wr_i && hit_opt;
  wire logic [31:0] header_d    = soft_rst_i            ? bib_pkg::RST_HEADER :
                                  (reg_wr_i && hit_hdr) ? reg_wdata_i : header_q;
  wire logic [3:0]  blk_code_d  = opt_wr ? reg_wdata_i[bib_pkg::BLK_MSB:bib_pkg::BLK_LSB] : blk_code_q;
  wire logic [7:0]  opt_lo_d    = opt_wr ? reg_wdata_i[bib_pkg::OPT_LO_LSB +: 8] : opt_lo_q;
  wire logic [4:0]  opt_hi_d    = opt_wr ? reg_wdata_i[bib_pkg::OPT_HI_LSB +: 5] : opt_hi_q;
  wire logic [31:0] uid_hi_d    = ee_load ? eeprom_uid_i[63:32] : (cfg_hi ? cfg_wdata_i : uid_hi_q);
  wire logic [31:0] uid_lo_d    = ee_load ? eeprom_uid_i[31:0] : (cfg_lo ? cfg_wdata_i : uid_lo_q);
  wire logic        hi_done_d   = hi_done_q || cfg_hi;
  wire logic        lo_done_d   = lo_done_q || cfg_lo;
  // Lock on an EEPROM load, or once both halves came by config write
  wire logic        locked_d    = locked_q || ee_load ||
                                  ((hi_done_q || cfg_hi) && (lo_done_q || cfg_lo));

  // Next values of the read ports; data holds between strobes
  wire logic [31:0] reg_rdata_d = reg_rd_i ? word_of(loc_quad, header_q, options_w, uid_hi_q, uid_lo_q)
                                           : reg_rdata_o;
  wire logic [31:0] rem_rdata_d = rem_rd_i ? word_of(rem_quad_i, header_q, options_w, uid_hi_q, uid_lo_q)
                                           : rem_rdata_o;

  // Stored registers
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      header_q <= bib_pkg::RST_HEADER;
    end
    else if (clk_en_i)
    begin
      header_q <= header_d;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      blk_code_q <= bib_pkg::BLK_RST;
    end
    else if (clk_en_i)
    begin
      blk_code_q <= blk_code_d;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      opt_lo_q <= bib_pkg::OPT_LO_RST;
    end
    else if (clk_en_i)
    begin
      opt_lo_q <= opt_lo_d;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      opt_hi_q <= bib_pkg::OPT_HI_RST;
    end
    else if (clk_en_i)
    begin
      opt_hi_q <= opt_hi_d;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      uid_hi_q <= bib_pkg::RST_UID;
    end
    else if (clk_en_i)
    begin
      uid_hi_q <= uid_hi_d;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      uid_lo_q <= bib_pkg::RST_UID;
    end
    else if (clk_en_i)
    begin
      uid_lo_q <= uid_lo_d;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hi_done_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      hi_done_q <= hi_done_d;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lo_done_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      lo_done_q <= lo_done_d;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      locked_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      locked_q <= locked_d;
    end
  end

  // Registered outputs
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      reg_rdata_o <= 32'h0000_0000;
    end
    else if (clk_en_i)
    begin
      reg_rdata_o <= reg_rdata_d;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rem_rdata_o <= 32'h0000_0000;
    end
    else if (clk_en_i)
    begin
      rem_rdata_o <= rem_rdata_d;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      blk_type_err_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      blk_type_err_o <= too_long;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      uid_locked_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      uid_locked_o <= locked_q;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      blk_code_o <= bib_pkg::BLK_RST;
    end
    else if (clk_en_i)
    begin
      blk_code_o <= blk_code_q;
    end
  end

endmodule // bib_regs

// File: test/bib_regs_monitor.sv
/* Port assertions for bib_regs. Assumes binding to every bib_regs instance. */
`timescale 1ns/100ps
module bib_regs_monitor
(
  // Clock, resets, enable
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire logic        soft_rst_i,
  input wire logic        clk_en_i,
  // Local register port
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_rdata_o,
  // Remote read and block-length check
  input wire logic        rem_rd_i,
  input wire logic [2:0]  rem_quad_i,
  input wire logic [31:0] rem_rdata_o,
  input wire logic        blk_wr_i,
  input wire logic [15:0] blk_len_i,
  input wire logic        blk_type_err_o,
  // Status
  input wire logic        uid_locked_o,
  input wire logic [3:0]  blk_code_o
);
  wire        rd  = reg_rd_i & clk_en_i;
  wire        rr  = rem_rd_i & clk_en_i;
  // Byte limit, codes under 8 count as 512
  wire [16:0] lim = 17'h0_0002 << ((blk_code_o < 4'h8) ? 4'h8 : blk_code_o);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  property p_name; rd && reg_addr_i == 8'h1c |=> reg_rdata_o == 32'h3133_3934; endproperty
  property p_rname; rr && rem_quad_i == 3'h1 |=> rem_rdata_o == 32'h3133_3934; endproperty
  property p_opt; rd && reg_addr_i == 8'h20 |=> (reg_rdata_o & 32'h0700_0fff) == 32'h0000_0002; endproperty
  property p_ropt; rr && rem_quad_i == 3'h2 |=> (rem_rdata_o & 32'h0700_0fff) == 32'h0000_0002; endproperty
  property p_lock; uid_locked_o |=> uid_locked_o; endproperty
  property p_blk;
    blk_wr_i && clk_en_i && $stable(blk_code_o) && !$past(reg_wr_i)
    |=> blk_type_err_o == ($past(lim) < {1'b0, $past(blk_len_i)});
  endproperty
  property p_rst; $rose(rst_b_i) |-> blk_code_o == 4'ha; endproperty
  property p_soft; soft_rst_i && clk_en_i && !reg_wr_i && !$past(reg_wr_i) |=> ##1 $stable(blk_code_o); endproperty
  a_name: assert property (p_name) else $error("bus name read wrong");
  a_rname: assert property (p_rname) else $error("remote bus name wrong");
  a_opt: assert property (p_opt) else $error("options fixed bits wrong");
  a_ropt: assert property (p_ropt) else $error("remote options wrong");
  a_lock: assert property (p_lock) else $error("identifier lock dropped");
  a_blk: assert property (p_blk) else $error("block type error wrong");
  a_rst: assert property (p_rst) else $error("block code not 2048 after reset");
  a_soft: assert property (p_soft) else $error("soft reset changed block code");
  c_lock: cover property (uid_locked_o);
  c_err: cover property (blk_type_err_o);
  c_soft: cover property (soft_rst_i);
endmodule // bib_regs_monitor
bind bib_regs bib_regs_monitor u_mon (.clock_i(clock_i), .rst_b_i(rst_b_i), .soft_rst_i(soft_rst_i),
  .clk_en_i(clk_en_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_rdata_o(reg_rdata_o), .rem_rd_i(rem_rd_i), .rem_quad_i(rem_quad_i), .rem_rdata_o(rem_rdata_o),
  .blk_wr_i(blk_wr_i), .blk_len_i(blk_len_i), .blk_type_err_o(blk_type_err_o),
  .uid_locked_o(uid_locked_o), .blk_code_o(blk_code_o));

// File: test/bib_eeprom_model.sv
/* Serial EEPROM identifier loader model. Assumes the bench commands each load. */
`timescale 1ns/100ps
module bib_eeprom_model
(
  input  wire logic        clock_i,
  input  wire logic        fit_i,
  input  wire logic        load_i,
  input  wire logic [63:0] uid_i,
  output logic             present_o,
  output logic             valid_o = 1'b0,
  output logic      [63:0] uid_o = 64'h0000_0000_0000_0000
);
  assign present_o = fit_i;
  // Data is only good in the valid cycle; otherwise it keeps toggling
  always @(posedge clock_i)
  begin
    valid_o <= load_i & fit_i;
    uid_o <= (load_i & fit_i) ? uid_i : ~uid_o;
  end
endmodule // bib_eeprom_model

// File: test/tb.sv
/* Self-checking bench for bib_regs. Assumes the monitor bind and the EEPROM model. */
`timescale 1ns/100ps
module tb;
  logic clock_i = 1'b0, rst_b_i = 1'b0, soft_rst_i = 1'b0, clk_en_i = 1'b1, reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0, cfg_wr_i = 1'b0, rem_rd_i = 1'b0, blk_wr_i = 1'b0, fit = 1'b0, load = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, cfg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000, cfg_wdata_i = 32'h0000_0000, reg_rdata_o, rem_rdata_o;
  logic [2:0] rem_quad_i = 3'h0;
  logic [15:0] blk_len_i = 16'h0000;
  logic [63:0] uid = 64'h0000_0000_0000_0000, eeprom_uid_i;
  logic eeprom_present_i, eeprom_valid_i, blk_type_err_o, uid_locked_o;
  logic [3:0] blk_code_o;
  int errors = 0, samples_checked = 0;
  logic [31:0] exp_q [5] = '{32'h0000_0000, 32'h3133_3934, 32'h0000_a002, 32'h0000_0000, 32'h0000_0000};
  always #2 clock_i = ~clock_i;
  bib_regs dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .soft_rst_i(soft_rst_i), .clk_en_i(clk_en_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
    .eeprom_present_i(eeprom_present_i), .eeprom_valid_i(eeprom_valid_i), .eeprom_uid_i(eeprom_uid_i),
    .rem_rd_i(rem_rd_i), .rem_quad_i(rem_quad_i), .rem_rdata_o(rem_rdata_o), .blk_wr_i(blk_wr_i),
    .blk_len_i(blk_len_i), .blk_type_err_o(blk_type_err_o), .uid_locked_o(uid_locked_o),
    .blk_code_o(blk_code_o));
  bib_eeprom_model u_eep (.clock_i(clock_i), .fit_i(fit), .load_i(load), .uid_i(uid),
    .present_o(eeprom_present_i), .valid_o(eeprom_valid_i), .uid_o(eeprom_uid_i));
  task automatic chk32(string n, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk1(string n, logic e, logic s);
    chk32(n, {31'h0, e}, {31'h0, s});
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    @(posedge clock_i) reg_wr_i <= 1'b0;
  endtask
  task automatic cw(logic [7:0] a, logic [31:0] d);
    @(posedge clock_i) {cfg_wr_i, cfg_addr_i, cfg_wdata_i} <= {1'b1, a, d};
    @(posedge clock_i) cfg_wr_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clock_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge clock_i) reg_rd_i <= 1'b0;
    #1 chk32($sformatf("reg %h", a), e, reg_rdata_o);
  endtask
  task automatic rr(logic [2:0] q, logic [31:0] e);
    @(posedge clock_i) {rem_rd_i, rem_quad_i} <= {1'b1, q};
    @(posedge clock_i) rem_rd_i <= 1'b0;
    #1 chk32($sformatf("quad %h", q), e, rem_rdata_o);
  endtask
  task automatic bk(logic [15:0] n, logic e);
    @(posedge clock_i) {blk_wr_i, blk_len_i} <= {1'b1, n};
    @(posedge clock_i) blk_wr_i <= 1'b0;
    #1 chk1("type_err", e, blk_type_err_o);
  endtask
  task automatic complete_run;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #20000;
    errors++;
    complete_run;
  end
  initial
  begin
    repeat (20) @(posedge clock_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      rd(8'h18 + 8'(i * 4), exp_q[i]);
      rr(3'(i), exp_q[i]);
    end
    rd(8'h2c, 32'h0000_0000);
    wr(8'h1c, 32'hffff_ffff);
    rd(8'h1c, 32'h3133_3934);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'hf8ff_f002);
    wr(8'h20, 32'h0000_8000);
    rr(3'h2, 32'h0000_8002);
    chk32("blk_code", 32'h0000_0008, {28'h000_0000, blk_code_o});
    bk(16'h0200, 1'b0);
    bk(16'h0201, 1'b1);
    wr(8'h18, 32'h1234_5678);
    rr(3'h0, 32'h1234_5678);
    // A write while the clock enable is low must not land
    @(posedge clock_i) clk_en_i <= 1'b0;
    wr(8'h18, 32'h0000_0000);
    @(posedge clock_i) clk_en_i <= 1'b1;
    rr(3'h0, 32'h1234_5678);
    @(posedge clock_i) soft_rst_i <= 1'b1;
    @(posedge clock_i) soft_rst_i <= 1'b0;
    rd(8'h20, 32'h0000_8002);
    rd(8'h18, 32'h0000_0000);
    cw(8'h70, 32'h1111_2222);
    cw(8'h84, 32'h3333_4444);
    repeat (3) @(posedge clock_i);
    #1 chk1("locked", 1'b1, uid_locked_o);
    cw(8'h80, 32'h5555_6666);
    wr(8'h24, 32'h5555_6666);
    rd(8'h24, 32'h1111_2222);
    rr(3'h4, 32'h3333_4444);
    @(posedge clock_i) {rst_b_i, fit, uid} <= {2'b01, 64'h0123_4567_89ab_cdef};
    @(posedge clock_i) rst_b_i <= 1'b1;
    rd(8'h20, 32'h0000_a002);
    chk32("blk_code", 32'h0000_000a, {28'h000_0000, blk_code_o});
    chk1("locked", 1'b0, uid_locked_o);
    // With an EEPROM present the config path stays shut
    cw(8'h70, 32'h7777_8888);
    rd(8'h24, 32'h0000_0000);
    @(posedge clock_i) load <= 1'b1;
    @(posedge clock_i) load <= 1'b0;
    repeat (3) @(posedge clock_i);
    rd(8'h24, 32'h0123_4567);
    rd(8'h28, 32'h89ab_cdef);
    chk1("locked", 1'b1, uid_locked_o);
    // Legacy alias offset 80h for the upper word; a second write to it is dropped
    @(posedge clock_i) {rst_b_i, fit} <= 2'b00;
    @(posedge clock_i) rst_b_i <= 1'b1;
    cw(8'h80, 32'haaaa_bbbb);
    cw(8'h80, 32'hcccc_dddd);
    #1 chk1("locked", 1'b0, uid_locked_o);
    cw(8'h74, 32'h0f0f_0f0f);
    repeat (2) @(posedge clock_i);
    #1 chk1("locked", 1'b1, uid_locked_o);
    rr(3'h3, 32'haaaa_bbbb);
    rr(3'h4, 32'h0f0f_0f0f);
    complete_run;
  end
endmodule // tb
